// >>> core/spdc_pkg.sv
/*
 * Constants, timing figures and the duty mapping for the servo PWM drive block.
 * Assumes a 40 MHz sys_clk and an 8-bit potentiometer conversion result at the port.
 */
// What this block does
// [RULE1] ramp off: fixed duty from max select
// [RULE2] PWM period fixed at 19.2 kHz
// [RULE3] sixteen duty steps over four PWM periods
// [RULE4] ramp on: mapped duty at start, pre-stop
// [RULE5] timer interval 15.625 or 31.25 ms
// [RULE6] full duty after fourteen timer intervals
// [RULE7] pre-stop index is absolute position difference
// [RULE8] mapping: index plus two, capped by select; spdc_map gives 14 for index 13
// [RULE9] actual duty is data plus one sixteenths
// [RULE10] drive starts 416 to 1250 us after command
// [RULE11] start duty follows the startup timer value
// [RULE12] zero difference stops motor at once
// [RULE13] pre-stop when timer exceeds difference, nonzero
// [RULE14] motor stalled: timer steps each interval
// [RULE15] duty unchanged when entering pre-stop
// [RULE16] pre-stop stalled: hold duty until arrival
// [RULE17] position 00h until acquired after 7.5 ms
// [RULE18] then position tracks one LSB per 833 us
// [RULE19] timing tick trimmed, tolerate 15 percent error
// [RULE20] CW a high, CCW b high, stop both low
// [RULE21] off portion of PWM is high impedance
package spdc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int PWM_HZ = 19_200;
    // rounds down: 520 cycles a quarter, period 2080 cycles
    localparam int QTR_CYC = CLK_HZ / (PWM_HZ * 4);
    localparam int TICK_NS = 1000;
    localparam logic [7:0] TRIM_RST = 8'(CLK_HZ / 1_000_000 * TICK_NS / 1000);
    localparam int ACQ_US = 7500;
    localparam int TRACK_US = 833;
    localparam int INT_SHORT_US = 15625;
    localparam int INT_LONG_US = 31250;
    localparam int START_DLY_US = 416;
    localparam int ACQ_TICKS = ACQ_US * 1000 / TICK_NS;
    localparam int TRACK_TICKS = TRACK_US * 1000 / TICK_NS;
    localparam int INT_SHORT_TICKS = INT_SHORT_US * 1000 / TICK_NS;
    localparam int INT_LONG_TICKS = INT_LONG_US * 1000 / TICK_NS;
    localparam int START_DLY_TICKS = START_DLY_US * 1000 / TICK_NS;

    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CMD = 4'h4;
    localparam logic [3:0] OFS_TRIM = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam int CTRL_RAMP_BIT = 2;
    localparam int CTRL_STEP_BIT = 3;
    localparam int CTRL_MAX_LO = 4;
    localparam int CTRL_MAX_HI = 5;

    localparam logic [3:0] DUTY_FULL = 4'hF;
    localparam logic [3:0] TMR_MAX = 4'hF;
    localparam logic [3:0] MAP_BASE = 4'h2;
    localparam logic [3:0] MAP_KNEE = 4'hC;
    localparam logic [3:0] CAP_00 = 4'hF;
    localparam logic [3:0] CAP_01 = 4'hA;
    localparam logic [3:0] CAP_10 = 4'h6;
    localparam logic [3:0] CAP_11 = 4'h3;

    typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_START, PH_PRESTOP} spdc_phase_t;

    function automatic logic [3:0] spdc_cap(input logic [1:0] sel);
        case (sel)
            2'h0: spdc_cap = CAP_00;
            2'h1: spdc_cap = CAP_01;
            2'h2: spdc_cap = CAP_10;
            default: spdc_cap = CAP_11;
        endcase
    endfunction

    function automatic logic [3:0] spdc_map(input logic [3:0] idx, input logic [1:0] sel);
        logic [3:0] raw;
        logic [3:0] cap;
        if (idx <= MAP_KNEE) begin
            raw = 4'(idx + MAP_BASE);
        end else if (idx == 4'(MAP_KNEE + 4'h1)) begin
            raw = 4'(MAP_KNEE + MAP_BASE);
        end else begin
            raw = DUTY_FULL;
        end
        cap = spdc_cap(sel);
        spdc_map = (raw > cap) ? cap : raw;
    endfunction
endpackage

// >>> core/spdc_top.sv
/*
 * Servo PWM drive: register port, position acquisition and tracking, start/pre-stop duty
 * control and the H-bridge PWM outputs with high-impedance off time.
 * Assumes pot_sense_input carries a settled conversion result synchronous to sys_clk.
 */
module spdc_top #(
    parameter int ACQ_T = spdc_pkg::ACQ_TICKS,
    parameter int TRACK_T = spdc_pkg::TRACK_TICKS,
    parameter int INT_SHORT_T = spdc_pkg::INT_SHORT_TICKS,
    parameter int INT_LONG_T = spdc_pkg::INT_LONG_TICKS,
    parameter int START_DLY_T = spdc_pkg::START_DLY_TICKS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [spdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] pot_sense_input,
    output logic motor_out_a,
    output logic motor_out_a_oe,
    output logic motor_out_b,
    output logic motor_out_b_oe
);
    import spdc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cmd;
        logic [7:0] trim;
        logic [31:0] rdata;
        logic go;
        logic [7:0] tick_cnt;
        logic tick;
        logic [15:0] pos_cnt;
        logic acq_done;
        logic [7:0] cur;
        spdc_phase_t ph;
        logic [15:0] ph_cnt;
        logic [3:0] tmr;
        logic [3:0] duty;
        logic [3:0] last_idx;
        logic cw;
        logic [9:0] qcnt;
        logic [1:0] qtr;
        logic [1:0] per;
        logic [3:0] frame_duty;
        logic out_a;
        logic oe_a;
        logic out_b;
        logic oe_b;
    } spdc_state_t;

    spdc_state_t s_q;
    spdc_state_t s_d;

    logic ramp;
    logic [1:0] sel;
    logic [7:0] diff;
    logic [3:0] idx;
    logic frame_end;
    logic [4:0] ons;
    logic [2:0] q_on;
    logic drive;
    logic pwm_on;
    logic [15:0] int_len;

    assign ramp = s_q.ctrl[CTRL_RAMP_BIT];
    assign sel = {s_q.ctrl[CTRL_MAX_HI], s_q.ctrl[CTRL_MAX_LO]};
    assign diff = (s_q.cmd > s_q.cur) ? 8'(s_q.cmd - s_q.cur) : 8'(s_q.cur - s_q.cmd); // [RULE7]
    assign idx = (diff > 8'h0F) ? 4'hF : diff[3:0];
    assign frame_end = (s_q.qcnt == 10'(QTR_CYC - 1)) && (&s_q.qtr) && (&s_q.per);
    assign int_len = s_q.ctrl[CTRL_STEP_BIT] ? 16'(INT_LONG_T) : 16'(INT_SHORT_T); // [RULE5]

    always_comb begin
        s_d = s_q;
        ons = '0;
        q_on = '0;
        drive = 1'b0;
        pwm_on = 1'b0;

        s_d.rdata = '0;
        s_d.go = reg_wr && (reg_addr == OFS_CMD);
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: s_d.ctrl = reg_wdata[7:0];
                OFS_CMD: s_d.cmd = reg_wdata[7:0];
                OFS_TRIM: s_d.trim = (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
                OFS_CMD: s_d.rdata = {24'h0, s_q.cmd};
                OFS_TRIM: s_d.rdata = {24'h0, s_q.trim};
                OFS_STAT: s_d.rdata = {12'h0, s_q.cw, s_q.acq_done, 2'(s_q.ph), s_q.tmr, s_q.duty, s_q.cur};
                default: s_d.rdata = '0;
            endcase
        end

        // software retunes the tick from the measured baud rate; until then nominal
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= 8'(s_q.trim - 8'h01)) begin // [RULE19]
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = 8'(s_q.tick_cnt + 8'h01);
        end

        if (s_q.tick) begin
            if (!s_q.acq_done) begin
                if (s_q.pos_cnt >= 16'(ACQ_T - 1)) begin // [RULE17]
                    s_d.cur = pot_sense_input;
                    s_d.acq_done = 1'b1;
                    s_d.pos_cnt = '0;
                end else begin
                    s_d.pos_cnt = 16'(s_q.pos_cnt + 16'h0001);
                end
            end else if (s_q.pos_cnt >= 16'(TRACK_T - 1)) begin
                s_d.pos_cnt = '0;
                if (pot_sense_input > s_q.cur) begin
                    s_d.cur = 8'(s_q.cur + 8'h01); // [RULE18]
                end else if (pot_sense_input < s_q.cur) begin
                    s_d.cur = 8'(s_q.cur - 8'h01); // [RULE18]
                end
            end else begin
                s_d.pos_cnt = 16'(s_q.pos_cnt + 16'h0001);
            end
        end

        case (s_q.ph)
            PH_IDLE: ;
            PH_DELAY: begin
                // fixed wait plus alignment to a four-period frame keeps the pattern whole
                if (s_q.ph_cnt < 16'(START_DLY_T)) begin
                    if (s_q.tick) begin
                        s_d.ph_cnt = 16'(s_q.ph_cnt + 16'h0001); // [RULE10]
                    end
                end else if (frame_end) begin
                    s_d.ph = PH_START;
                    s_d.ph_cnt = '0;
                    s_d.tmr = '0;
                    s_d.duty = ramp ? spdc_map(4'h0, sel) : spdc_cap(sel); // [RULE11]
                end
            end
            PH_START: begin
                if (!ramp) begin
                    s_d.duty = spdc_cap(sel); // [RULE1]
                end else if ((s_q.tmr > idx) && (diff != 8'h00)) begin
                    s_d.ph = PH_PRESTOP; // [RULE13]
                    s_d.last_idx = idx; // [RULE15]
                end else begin
                    if (s_q.tick) begin
                        if (s_q.ph_cnt >= 16'(int_len - 16'h0001)) begin
                            s_d.ph_cnt = '0;
                            if (s_q.tmr != TMR_MAX) begin
                                s_d.tmr = 4'(s_q.tmr + 4'h1); // [RULE14]
                            end
                        end else begin
                            s_d.ph_cnt = 16'(s_q.ph_cnt + 16'h0001);
                        end
                    end
                    // a timer step that crosses the difference hands over at the old duty
                    if ((s_d.tmr > idx) && (diff != 8'h00)) begin
                        s_d.ph = PH_PRESTOP; // [RULE13]
                        s_d.last_idx = idx; // [RULE15]
                    end else begin
                        s_d.duty = spdc_map(s_d.tmr, sel); // [RULE4] [RULE6] [RULE8]
                    end
                end
            end
            PH_PRESTOP: begin
                if (!ramp) begin
                    s_d.duty = spdc_cap(sel); // [RULE1]
                end else if (idx != s_q.last_idx) begin
                    // a stalled motor leaves idx alone, so the duty holds
                    s_d.duty = spdc_map(idx, sel); // [RULE4] [RULE16]
                    s_d.last_idx = idx;
                end
            end
            default: s_d.ph = PH_IDLE;
        endcase

        if (s_q.go) begin
            s_d.ph = (diff != 8'h00) ? PH_DELAY : PH_IDLE;
            s_d.ph_cnt = '0;
            s_d.cw = s_q.cmd > s_q.cur;
        end else if ((s_q.ph != PH_IDLE) && (diff == 8'h00)) begin
            s_d.ph = PH_IDLE; // [RULE12]
        end

        if (s_q.qcnt == 10'(QTR_CYC - 1)) begin // [RULE2]
            s_d.qcnt = '0;
            s_d.qtr = 2'(s_q.qtr + 2'h1);
            if (&s_q.qtr) begin
                s_d.per = 2'(s_q.per + 2'h1);
            end
        end else begin
            s_d.qcnt = 10'(s_q.qcnt + 10'h001);
        end
        if (frame_end) begin
            s_d.frame_duty = s_d.duty;
        end
        // data d gives d+1 quarters per frame, spread evenly over the four periods
        ons = 5'(s_d.frame_duty + 5'h01); // [RULE9]
        q_on = 3'(ons[4:2] + 3'((s_d.per < ons[1:0]) ? 1 : 0)); // [RULE3]
        pwm_on = {1'b0, s_d.qtr} < q_on;
        drive = (s_d.ph == PH_START) || (s_d.ph == PH_PRESTOP);

        if (!drive) begin
            s_d.out_a = 1'b0; // [RULE20]
            s_d.out_b = 1'b0;
            s_d.oe_a = 1'b1;
            s_d.oe_b = 1'b1;
        end else if (pwm_on) begin
            s_d.out_a = s_d.cw; // [RULE20]
            s_d.out_b = !s_d.cw;
            s_d.oe_a = 1'b1;
            s_d.oe_b = 1'b1;
        end else begin
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
            s_d.oe_a = 1'b0; // [RULE21]
            s_d.oe_b = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{ctrl: CTRL_RST, cmd: CMD_RST, trim: TRIM_RST, rdata: 32'h0, go: 1'b0,
                     tick_cnt: 8'h00, tick: 1'b0, pos_cnt: 16'h0000, acq_done: 1'b0, cur: 8'h00,
                     ph: PH_IDLE, ph_cnt: 16'h0000, tmr: 4'h0, duty: 4'h0, last_idx: 4'h0, cw: 1'b0,
                     qcnt: 10'h000, qtr: 2'h0, per: 2'h0, frame_duty: 4'h0,
                     out_a: 1'b0, oe_a: 1'b1, out_b: 1'b0, oe_b: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign motor_out_a = s_q.out_a;
    assign motor_out_a_oe = s_q.oe_a;
    assign motor_out_b = s_q.out_b;
    assign motor_out_b_oe = s_q.oe_b;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    fixed_duty_cap_a: assert property ((s_q.ph == PH_START) && !ramp |=> // [RULE1]
        (s_q.ph != PH_START) || !ramp || $changed(sel) || (s_q.duty == spdc_cap($past(sel))))
        else $error("fixed duty differs from max select");
    pwm_quarter_wrap_a: assert property (1'b1 |=> (s_q.qcnt <= 10'(QTR_CYC - 1)) && (s_q.qcnt == // [RULE2]
        (($past(s_q.qcnt) == 10'(QTR_CYC - 1)) ? 10'h000 : 10'($past(s_q.qcnt) + 10'h001))))
        else $error("pwm quarter length wrong");
    full_drive_on_a: assert property ((s_q.frame_duty == DUTY_FULL) && $stable(s_q.frame_duty) // [RULE9]
        && ($past(s_q.ph) == PH_START) && (s_q.ph == PH_START) |-> s_q.oe_a && s_q.oe_b)
        else $error("full duty shows an off portion");
    stop_on_zero_a: assert property ((s_q.ph != PH_IDLE) && (diff == 8'h00) && !s_q.go // [RULE12]
        |=> (s_q.ph == PH_IDLE) && !motor_out_a && !motor_out_b)
        else $error("motor not stopped at zero difference");
    prestop_entry_a: assert property ((s_q.ph == PH_START) && ramp && (s_q.tmr > idx) && (diff != 8'h00) // [RULE13]
        && !s_q.go |=> (s_q.ph == PH_PRESTOP) && $stable(s_q.duty))
        else $error("pre-stop entry wrong or duty moved");
    no_early_prestop_a: assert property ((s_q.ph != PH_START) ##1 (s_q.ph == PH_PRESTOP) // [RULE13]
        |-> $past(s_q.ph) == PH_PRESTOP)
        else $error("pre-stop entered from wrong phase");
    timer_step_a: assert property ((s_q.ph == PH_START) && ramp && s_q.tick && !s_q.go && (diff != 8'h00) // [RULE14]
        && !(s_q.tmr > idx) && (s_q.ph_cnt == 16'(int_len - 16'h0001)) && (s_q.tmr != TMR_MAX)
        |=> s_q.tmr == 4'($past(s_q.tmr) + 4'h1))
        else $error("startup timer did not step");
    start_map_a: assert property ((s_q.ph == PH_START) && ramp |-> s_q.duty == spdc_map(s_q.tmr, sel) // [RULE11]
        or $changed(sel) or $past(!ramp))
        else $error("start duty not from timer");
    acq_zero_a: assert property (!s_q.acq_done |-> s_q.cur == 8'h00) // [RULE17]
        else $error("position reported before acquisition");
    track_step_a: assert property ($past(s_q.acq_done) && $changed(s_q.cur) // [RULE18]
        |-> (8'(s_q.cur - $past(s_q.cur)) == 8'h01) || (8'($past(s_q.cur) - s_q.cur) == 8'h01))
        else $error("position moved by more than one step");
    dir_exclusive_a: assert property (motor_out_a |-> !motor_out_b && motor_out_a_oe) // [RULE20]
        else $error("both bridge sides high");
    delay_no_drive_a: assert property ((s_q.ph == PH_DELAY) |-> !motor_out_a && !motor_out_b // [RULE10]
        && motor_out_a_oe && motor_out_b_oe)
        else $error("drive before start delay expired");

    prestop_seen_c: cover property ((s_q.ph == PH_START) ##1 (s_q.ph == PH_PRESTOP));
    stop_from_start_c: cover property ((s_q.ph == PH_START) ##1 (s_q.ph == PH_IDLE));
    fixed_run_c: cover property ((s_q.ph == PH_START) && !ramp && motor_out_a);
    ccw_run_c: cover property (motor_out_b && (s_q.ph == PH_PRESTOP));
endmodule // spdc_top

// >>> sim/servo_pwm_drive_control_tb.sv
/* Self-checking bench for spdc_top: registers, acquisition, fixed and ramped PWM, pre-stop.
 * Assumes spdc_pkg and spdc_motor_model; timing parameters shortened, tick trimmed to 20 cycles. */
module servo_pwm_drive_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spdc_pkg::*;
    localparam int TR = 20;
    localparam int FR = 16 * QTR_CYC;
    typedef struct {logic [7:0] ctrl; logic [7:0] cmd; int q; logic cw;} spdc_row_t;
    spdc_row_t rows [4];
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] pot;
    logic motor_out_a, motor_out_a_oe, motor_out_b, motor_out_b_oe;
    logic stall = 1'b1;
    logic load = 1'b0;
    logic [7:0] load_val = 8'h00;
    logic [31:0] st;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n, on, on0, offz, wrong, q;

    always #12.5 sys_clk = ~sys_clk;

    spdc_top #(.ACQ_T(20), .TRACK_T(5), .INT_SHORT_T(15), .INT_LONG_T(30), .START_DLY_T(10)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pot_sense_input(pot),
        .motor_out_a(motor_out_a), .motor_out_a_oe(motor_out_a_oe),
        .motor_out_b(motor_out_b), .motor_out_b_oe(motor_out_b_oe));

    spdc_motor_model #(.MOVE_CYC(300)) u_motor (
        .sys_clk(sys_clk), .resetn(resetn), .motor_out_a(motor_out_a), .motor_out_a_oe(motor_out_a_oe),
        .motor_out_b(motor_out_b), .motor_out_b_oe(motor_out_b_oe), .stall(stall), .load(load),
        .load_val(load_val), .pot_sense_input(pot));

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // planned traffic stays just under 100k cycles; frame alignment dominates
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 110000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %0h seen %0h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 st = reg_rdata;
    endtask

    function automatic logic [3:0] exp_map(input logic [3:0] i, input logic [1:0] s);
        logic [3:0] r;
        logic [3:0] c;
        r = (i <= 4'hC) ? i + 4'h2 : (i == 4'hD) ? 4'hE : 4'hF;
        c = (s == 2'h0) ? 4'hF : (s == 2'h1) ? 4'hA : (s == 2'h2) ? 4'h6 : 4'h3;
        exp_map = (r > c) ? c : r;
    endfunction

    task automatic wait_drive();
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!((motor_out_a_oe && motor_out_a) || (motor_out_b_oe && motor_out_b)) && n < 20000);
    endtask

    task automatic stop_check();
        reg_write(OFS_CMD, 32'h44);
        repeat (3) @(negedge sys_clk);
        chk("stop pins", 4'h5, {motor_out_a, motor_out_a_oe, motor_out_b, motor_out_b_oe});
    endtask

    task automatic ramp_run(input logic [7:0] ctl, input logic [3:0] lo, input logic [3:0] hi);
        reg_write(OFS_CTRL, {24'h0, ctl});
        reg_write(OFS_CMD, 32'h64);
        wait_drive();
        reg_read(OFS_STAT);
        chk("start timer", 0, st[15:12]);
        chk("start duty", exp_map(4'h0, ctl[5:4]), st[11:8]);
        repeat (16) begin
            repeat (15 * TR) @(negedge sys_clk);
            reg_read(OFS_STAT);
            chk("ramp duty", exp_map(st[15:12], ctl[5:4]), st[11:8]);
        end
        chk("timer span", 1, st[15:12] >= lo && st[15:12] <= hi);
        stop_check();
    endtask

    initial begin
        rows = '{'{8'h00, 8'h50, 16, 1'b1}, '{8'h10, 8'h30, 11, 1'b0},
                 '{8'h28, 8'h60, 7, 1'b1}, '{8'h30, 8'h20, 4, 1'b0}};
        repeat (5) @(posedge sys_clk);
        chk("reset pins", 4'h5, {motor_out_a, motor_out_a_oe, motor_out_b, motor_out_b_oe});
        resetn <= 1'b1;
        reg_read(OFS_CTRL);
        chk("ctrl reset", 0, st);
        reg_read(OFS_TRIM);
        chk("trim reset", {24'h0, TRIM_RST}, st);
        repeat (2) @(negedge sys_clk);
        chk("rdata idle", 0, reg_rdata);
        reg_read(OFS_STAT);
        chk("early pos", 9'h000, {st[18], st[7:0]});
        reg_write(4'h2, 32'hFF);
        reg_read(4'h2);
        chk("unmapped", 0, st);
        reg_read(OFS_CMD);
        chk("cmd reset", 0, st);
        repeat (900) @(negedge sys_clk);
        reg_read(OFS_STAT);
        chk("acquired", 9'h140, {st[18], st[7:0]});
        reg_write(OFS_TRIM, TR);
        @(posedge sys_clk);
        load <= 1'b1;
        load_val <= 8'h44;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (30) @(negedge sys_clk);
        reg_read(OFS_STAT);
        chk("track step", 1, st[7:0] == 8'h40 || st[7:0] == 8'h41);
        repeat (600) @(negedge sys_clk);
        reg_read(OFS_STAT);
        chk("track end", 8'h44, st[7:0]);
        foreach (rows[i]) begin
            reg_write(OFS_CTRL, {24'h0, rows[i].ctrl});
            reg_write(OFS_CMD, {24'h0, rows[i].cmd});
            wait_drive();
            chk("start lat", 1, n >= 9 * TR && n <= 11 * TR + FR + 4);
            on = 0;
            on0 = 0;
            offz = 0;
            wrong = 0;
            for (int k = 0; k < FR; k++) begin
                if (k > 0) @(negedge sys_clk);
                if (rows[i].cw ? (motor_out_a_oe && motor_out_a) : (motor_out_b_oe && motor_out_b)) begin
                    on++;
                    if (k < 4 * QTR_CYC) on0++;
                end
                if (rows[i].cw ? (motor_out_b_oe && motor_out_b) : (motor_out_a_oe && motor_out_a)) wrong++;
                if (!motor_out_a_oe && !motor_out_b_oe) offz++;
            end
            q = rows[i].q;
            chk("on cycles", q * QTR_CYC, on);
            chk("period on", (q / 4 + (q % 4 != 0)) * QTR_CYC, on0);
            chk("off float", (16 - q) * QTR_CYC, offz);
            chk("wrong side", 0, wrong);
            reg_read(OFS_STAT);
            chk("fixed duty", q - 1, st[11:8]);
            chk("cw flag", rows[i].cw, st[19]);
            stop_check();
        end
        ramp_run(8'h04, 4'hF, 4'hF);
        ramp_run(8'h3C, 4'h7, 4'h9);
        reg_write(OFS_CTRL, 32'h04);
        reg_write(OFS_CMD, 32'h47);
        wait_drive();
        n = 0;
        do begin reg_read(OFS_STAT); n++; end while (st[17:16] !== 2'h3 && n < 5000);
        chk("entry timer", 4, st[15:12]);
        chk("entry duty", 5, st[11:8]);
        repeat (45 * TR) @(negedge sys_clk);
        reg_read(OFS_STAT);
        chk("stall hold", 6'h35, {st[17:16], st[11:8]});
        chk("stall timer", 4, st[15:12]);
        @(posedge sys_clk);
        stall <= 1'b0;
        n = 0;
        do begin reg_read(OFS_STAT); n++; end while (st[7:0] !== 8'h46 && n < 5000);
        repeat (20) @(negedge sys_clk);
        reg_read(OFS_STAT);
        chk("diff duty", 3, st[11:8]);
        n = 0;
        do begin reg_read(OFS_STAT); n++; end while (st[17:16] !== 2'h0 && n < 5000);
        chk("arrive pos", 8'h47, st[7:0]);
        repeat (3) @(negedge sys_clk);
        chk("arrive pins", 4'h5, {motor_out_a, motor_out_a_oe, motor_out_b, motor_out_b_oe});
        summarize();
    end
endmodule // servo_pwm_drive_control_tb

// >>> sim/spdc_motor_model.sv
/* Behavioural DC motor with potentiometer for the servo PWM bench.
 * Assumes bridge pins as level plus enable; a released pin carries no current. */
module spdc_motor_model #(
    parameter int MOVE_CYC = 800,
    parameter logic [7:0] START_POS = 8'h40
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic motor_out_a,
    input wire logic motor_out_a_oe,
    input wire logic motor_out_b,
    input wire logic motor_out_b_oe,
    input wire logic stall,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic [7:0] pot_sense_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic push_cw;
    logic push_ccw;
    int acc_q;
    // floating side gives no torque, so only a driven high side pushes
    assign push_cw = motor_out_a_oe && motor_out_a && !(motor_out_b_oe && motor_out_b);
    assign push_ccw = motor_out_b_oe && motor_out_b && !(motor_out_a_oe && motor_out_a);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pot_sense_input <= START_POS;
            acc_q <= 0;
        end else if (load) begin
            pot_sense_input <= load_val;
            acc_q <= 0;
        end else if (!stall && (push_cw || push_ccw)) begin
            if (acc_q == MOVE_CYC - 1) begin
                acc_q <= 0;
                pot_sense_input <= push_cw ? pot_sense_input + 8'h01 : pot_sense_input - 8'h01;
            end else begin
                acc_q <= acc_q + 1;
            end
        end
    end
endmodule // spdc_motor_model
